//--- design/rtca_map.vh
`ifndef RTCA_MAP_VH
`define RTCA_MAP_VH

// ========================================
// Register indices (byte address is four times the index)
`define RTCA_IDX_CAL_SEC 8'h40
`define RTCA_IDX_CAL_MIN 8'h41
`define RTCA_IDX_CAL_HOUR 8'h42
`define RTCA_IDX_CAL_DAY 8'h43
`define RTCA_IDX_CAL_MON 8'h44
`define RTCA_IDX_CAL_YEAR 8'h45
`define RTCA_IDX_ALM_SEC 8'h46
`define RTCA_IDX_ALM_MIN 8'h47
`define RTCA_IDX_ALM_HOUR 8'h48
`define RTCA_IDX_ALM_DAY 8'h49
`define RTCA_IDX_ALM_MON 8'h4a
`define RTCA_IDX_ALM_YEAR 8'h4b
`define RTCA_IDX_SCNT_B0 8'h4c
`define RTCA_IDX_SCNT_B1 8'h4d
`define RTCA_IDX_SCNT_B2 8'h4e
`define RTCA_IDX_SCNT_B3 8'h4f

// ========================================
// Field positions
`define RTCA_RDFLAG_BIT 7
`define RTCA_MONITOR_BIT 6
`define RTCA_TICK_WAKE_BIT 5
`define RTCA_TICK_TYPE_BIT 4
`define RTCA_TICK_ON_BIT 7
`define RTCA_ALARM_ON_BIT 6

// ========================================
// Field limits and reset values
`define RTCA_SEC_MAX 6'h3b
`define RTCA_HOUR_MAX 5'h17
`define RTCA_MON_MAX 4'hc
`define RTCA_YEAR_MAX 6'h3f
`define RTCA_RST_SEC 6'h00
`define RTCA_RST_HOUR 5'h00
`define RTCA_RST_DAY 5'h01
`define RTCA_RST_MON 4'h1
`define RTCA_RST_YEAR 6'h00

// ========================================
// Alarm cause codes and bus responses
`define RTCA_CAUSE_NONE 2'b00
`define RTCA_CAUSE_TICK 2'b01
`define RTCA_CAUSE_ALARM 2'b10
`define RTCA_RESP_OKAY 2'b00
`define RTCA_RESP_DECERR 2'b11

// ========================================
// Timing
`define RTCA_CLK_HZ 20000000
`define RTCA_SEC_PERIOD_MS 1000
`define RTCA_HOLD_MS 500
`define RTCA_SEC_CYCLES (`RTCA_CLK_HZ / 1000 * `RTCA_SEC_PERIOD_MS)
`define RTCA_HOLD_CYCLES (`RTCA_CLK_HZ / 1000 * `RTCA_HOLD_MS)

`endif

//--- design/rtca_cal_core.v
`timescale 1ns/1ns
`include "rtca_map.vh"

module rtca_cal_core
(
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Control
    input wire sec_en,
    input wire load,
    // Load values
    input wire [5:0] ld_sec,
    input wire [5:0] ld_min,
    input wire [4:0] ld_hour,
    input wire [4:0] ld_day,
    input wire [3:0] ld_mon,
    input wire [5:0] ld_year,
    // Running calendar
    output reg [5:0] sec_q,
    output reg [5:0] min_q,
    output reg [4:0] hour_q,
    output reg [4:0] day_q,
    output reg [3:0] mon_q,
    output reg [5:0] year_q
);

    // ========================================
    // Month length; year offset 0 is a leap year, as every fourth after it
    function [4:0] last_day;
        input [3:0] mon;
        input [5:0] year;
        begin
            case (mon)
                4'h2: last_day = (year[1:0] == 2'b00) ? 5'd29 : 5'd28;
                4'h4, 4'h6, 4'h9, 4'hb: last_day = 5'd30;
                default: last_day = 5'd31;
            endcase
        end
    endfunction

    // ========================================
    // Counters
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sec_q <= `RTCA_RST_SEC;
            min_q <= `RTCA_RST_SEC;
            hour_q <= `RTCA_RST_HOUR;
            day_q <= `RTCA_RST_DAY;
            mon_q <= `RTCA_RST_MON;
            year_q <= `RTCA_RST_YEAR;
        end
        else if (load)
        begin
            // Whole calendar at once
            sec_q <= ld_sec;
            min_q <= ld_min;
            hour_q <= ld_hour;
            day_q <= ld_day;
            mon_q <= ld_mon;
            year_q <= ld_year;
        end
        else if (sec_en)
        begin
            sec_q <= (sec_q >= `RTCA_SEC_MAX) ? 6'h00 : sec_q + 6'h01;
            if (sec_q >= `RTCA_SEC_MAX)
            begin
                min_q <= (min_q >= `RTCA_SEC_MAX) ? 6'h00 : min_q + 6'h01;
                if (min_q >= `RTCA_SEC_MAX)
                begin
                    hour_q <= (hour_q >= `RTCA_HOUR_MAX) ? 5'h00 : hour_q + 5'h01;
                    if (hour_q >= `RTCA_HOUR_MAX)
                    begin
                        // Day numbering starts at one
                        day_q <= (day_q >= last_day(mon_q, year_q)) ? 5'h01 : day_q + 5'h01;
                        if (day_q >= last_day(mon_q, year_q))
                        begin
                            mon_q <= (mon_q >= `RTCA_MON_MAX) ? 4'h1 : mon_q + 4'h1;
                            if (mon_q >= `RTCA_MON_MAX)
                                year_q <= year_q + 6'h01;
                        end
                    end
                end
            end
        end
    end

endmodule // rtca_cal_core

//--- design/rtca_regs.v
`timescale 1ns/1ns
`include "rtca_map.vh"
// Functional notes
// - Hour field is 5 bits in 4:0, 0x00-0x17; bits 7:5 read zero.
// - Day field is 5 bits, 0x01-0x1F, numbering starts at one.
// - Month field is 4 bits in 3:0, 0x01-0x0C; bits 7:4 read zero.
// - Year field is 6-bit offset in 5:0, zero meaning year 2000.
// - Writing year loads all buffered calendar fields into the counters together.
// - Monitor bit 6 of year reads 0 after power loss, 1 when valid.
// - Software writes 1 to arm monitor; writing 0 is ignored.
// - Alarm cause in alarm seconds bits 7:6: none, tick, alarm, both.
// - Alarm seconds and minutes fields are 6 bits, 0x00-0x3B, writable.
// - Alm_hour_field, day and month fields writable, same widths as calendar.
// - Alm_month_field bit 5 enables tick wake-up.
// - Alm_month_field bit 4 selects tick each second or each minute.
// - Alarm year bit 7 enables periodic ticks.
// - Alarm year bit 6 enables the calendar-match alarm.
// - Alarm year is 6 bits; writing it commits minutes through year.
// - Reading counter byte 0 snapshots the 32-bit seconds counter.
// - Counter bytes run least significant 0x4C up to most significant 0x4F.
// - Reading calendar seconds snapshots the calendar into seconds-to-year registers.
// - Calendar seconds and minutes are 6 bits, 0x00-0x3B.
// - Seconds bit 7 always reads 1, as each seconds read copies the calendar into readable registers.

module rtca_regs
#(
    parameter ADDR_W = 12,
    parameter SEC_CYCLES = `RTCA_SEC_CYCLES,
    parameter HOLD_CYCLES = `RTCA_HOLD_CYCLES
)
(
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // AXI4-Lite write address and data
    input wire [ADDR_W-1:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // AXI4-Lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Time base supervision
    input wire pwr_lost,
    // Events
    output reg tick_event_q,
    output reg alarm_event_q,
    output reg wake_q,
    output reg clock_valid_q
);

    // ========================================
    // Address decode
    function mapped;
        input [ADDR_W-1:0] addr;
        begin
            mapped = (addr[ADDR_W-1:10] == 0) && (addr[9:6] == 4'h4);
        end
    endfunction

    function [7:0] idx_of;
        input [ADDR_W-1:0] addr;
        begin
            idx_of = addr[9:2];
        end
    endfunction

    // ========================================
    // Declarations
    wire [5:0] cal_sec;
    wire [5:0] cal_min;
    wire [4:0] cal_hour;
    wire [4:0] cal_day;
    wire [3:0] cal_mon;
    wire [5:0] cal_year;
    reg [5:0] sh_sec_q;
    reg [5:0] sh_min_q;
    reg [4:0] sh_hour_q;
    reg [4:0] sh_day_q;
    reg [3:0] sh_mon_q;
    reg [5:0] sh_year_q;
    reg rdflag_q;
    reg [31:0] hold_cnt_q;
    reg [5:0] alm_sec_q;
    reg [5:0] alm_min_q;
    reg [4:0] alm_hour_q;
    reg [4:0] alm_day_q;
    reg [3:0] alm_mon_q;
    reg [5:0] alm_year_q;
    reg tick_wake_q;
    reg tick_type_q;
    reg tick_on_q;
    reg alarm_on_q;
    reg [5:0] cmp_min_q;
    reg [4:0] cmp_hour_q;
    reg [4:0] cmp_day_q;
    reg [3:0] cmp_mon_q;
    reg [5:0] cmp_year_q;
    reg [1:0] cause_q;
    reg [1:0] cause_d;
    reg [31:0] scnt_q;
    reg [31:0] scnt_snap_q;
    reg [31:0] div_q;
    reg sec_en_q;
    reg chk_q;
    reg [7:0] rd_idx_q;
    reg rd_ok_q;
    reg [7:0] rd_byte;
    reg tick_hit;
    reg alarm_hit;
    wire do_wr;
    wire do_rd;
    wire [7:0] wr_idx;
    wire wr_en;
    wire [7:0] wb;
    wire ld_cal;
    wire rd_now;

    assign do_wr = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
    assign do_rd = s_axi_arvalid && !s_axi_arready && !rd_ok_q && !s_axi_rvalid;
    assign wr_idx = idx_of(s_axi_awaddr);
    // Only byte lane 0 carries register data; other lanes are dropped
    assign wr_en = do_wr && mapped(s_axi_awaddr) && s_axi_wstrb[0];
    assign wb = s_axi_wdata[7:0];
    assign ld_cal = wr_en && (wr_idx == `RTCA_IDX_CAL_YEAR);
    assign rd_now = s_axi_arready;

    // ========================================
    // Calendar counters
    rtca_cal_core u_cal
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .sec_en(sec_en_q),
        .load(ld_cal),
        .ld_sec(sh_sec_q),
        .ld_min(sh_min_q),
        .ld_hour(sh_hour_q),
        .ld_day(sh_day_q),
        .ld_mon(sh_mon_q),
        .ld_year(wb[5:0]),
        .sec_q(cal_sec),
        .min_q(cal_min),
        .hour_q(cal_hour),
        .day_q(cal_day),
        .mon_q(cal_mon),
        .year_q(cal_year)
    );

    // ========================================
    // One-second enable and free-running counter
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            div_q <= 32'h0000_0000;
            sec_en_q <= 1'b0;
            chk_q <= 1'b0;
            scnt_q <= 32'h0000_0000;
        end
        else
        begin
            sec_en_q <= (div_q == SEC_CYCLES - 1);
            div_q <= (div_q == SEC_CYCLES - 1) ? 32'h0000_0000 : div_q + 32'h0000_0001;
            // Compare one cycle later, once the calendar has stepped
            chk_q <= sec_en_q;
            if (sec_en_q)
                scnt_q <= scnt_q + 32'h0000_0001;
        end
    end

    // ========================================
    // AXI4-Lite handshake
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RTCA_RESP_OKAY;
            s_axi_arready <= 1'b0;
            rd_ok_q <= 1'b0;
            rd_idx_q <= 8'h00;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `RTCA_RESP_OKAY;
            s_axi_rdata <= 32'h0000_0000;
        end
        else
        begin
            s_axi_awready <= do_wr;
            s_axi_wready <= do_wr;
            if (s_axi_awready)
                s_axi_bvalid <= 1'b1;
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (do_wr)
                s_axi_bresp <= mapped(s_axi_awaddr) ? `RTCA_RESP_OKAY : `RTCA_RESP_DECERR;
            s_axi_arready <= do_rd;
            if (do_rd)
            begin
                rd_ok_q <= mapped(s_axi_araddr);
                rd_idx_q <= idx_of(s_axi_araddr);
            end
            // Data are formed at the address handshake, after which the side effects act
            if (rd_now)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h00_0000, rd_byte};
                s_axi_rresp <= rd_ok_q ? `RTCA_RESP_OKAY : `RTCA_RESP_DECERR;
                rd_ok_q <= 1'b0;
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // ========================================
    // Read data
    always @*
    begin
        rd_byte = 8'h00;
        if (rd_ok_q)
        begin
            case (rd_idx_q)
                // Live seconds and counter byte 0: the snapshot is taken by this very read
                `RTCA_IDX_CAL_SEC: rd_byte = {1'b1, 1'b0, cal_sec};
                `RTCA_IDX_CAL_MIN: rd_byte = {2'b00, sh_min_q};
                `RTCA_IDX_CAL_HOUR: rd_byte = {3'b000, sh_hour_q};
                `RTCA_IDX_CAL_DAY: rd_byte = {3'b000, sh_day_q};
                `RTCA_IDX_CAL_MON: rd_byte = {4'h0, sh_mon_q};
                `RTCA_IDX_CAL_YEAR: rd_byte = {1'b0, clock_valid_q, sh_year_q};
                `RTCA_IDX_ALM_SEC: rd_byte = {cause_q, alm_sec_q};
                `RTCA_IDX_ALM_MIN: rd_byte = {2'b00, alm_min_q};
                `RTCA_IDX_ALM_HOUR: rd_byte = {3'b000, alm_hour_q};
                `RTCA_IDX_ALM_DAY: rd_byte = {3'b000, alm_day_q};
                `RTCA_IDX_ALM_MON: rd_byte = {2'b00, tick_wake_q, tick_type_q, alm_mon_q};
                `RTCA_IDX_ALM_YEAR: rd_byte = {tick_on_q, alarm_on_q, alm_year_q};
                `RTCA_IDX_SCNT_B0: rd_byte = scnt_q[7:0];
                `RTCA_IDX_SCNT_B1: rd_byte = scnt_snap_q[15:8];
                `RTCA_IDX_SCNT_B2: rd_byte = scnt_snap_q[23:16];
                `RTCA_IDX_SCNT_B3: rd_byte = scnt_snap_q[31:24];
                default: rd_byte = 8'h00;
            endcase
        end
    end

    // ========================================
    // Calendar shadow: snapshot on read, software buffer on write
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sh_sec_q <= `RTCA_RST_SEC;
            sh_min_q <= `RTCA_RST_SEC;
            sh_hour_q <= `RTCA_RST_HOUR;
            sh_day_q <= `RTCA_RST_DAY;
            sh_mon_q <= `RTCA_RST_MON;
            sh_year_q <= `RTCA_RST_YEAR;
            rdflag_q <= 1'b0;
            hold_cnt_q <= 32'h0000_0000;
            scnt_snap_q <= 32'h0000_0000;
        end
        else
        begin
            if (rd_now && rd_ok_q && rd_idx_q == `RTCA_IDX_CAL_SEC)
            begin
                sh_sec_q <= cal_sec;
                sh_min_q <= cal_min;
                sh_hour_q <= cal_hour;
                sh_day_q <= cal_day;
                sh_mon_q <= cal_mon;
                sh_year_q <= cal_year;
                rdflag_q <= 1'b1;
                hold_cnt_q <= HOLD_CYCLES;
            end
            else if (hold_cnt_q != 32'h0000_0000)
            begin
                // The copy is only promised coherent for the hold window
                hold_cnt_q <= hold_cnt_q - 32'h0000_0001;
                if (hold_cnt_q == 32'h0000_0001)
                    rdflag_q <= 1'b0;
            end
            if (rd_now && rd_ok_q && rd_idx_q == `RTCA_IDX_SCNT_B0)
                scnt_snap_q <= scnt_q;
            // A write in the same cycle as a snapshot wins
            if (wr_en)
            begin
                case (wr_idx)
                    `RTCA_IDX_CAL_SEC: sh_sec_q <= wb[5:0];
                    `RTCA_IDX_CAL_MIN: sh_min_q <= wb[5:0];
                    `RTCA_IDX_CAL_HOUR: sh_hour_q <= wb[4:0];
                    `RTCA_IDX_CAL_DAY: sh_day_q <= wb[4:0];
                    `RTCA_IDX_CAL_MON: sh_mon_q <= wb[3:0];
                    `RTCA_IDX_CAL_YEAR: sh_year_q <= wb[5:0];
                    default: sh_sec_q <= sh_sec_q;
                endcase
            end
        end
    end

    // ========================================
    // Clock monitor
    always @(posedge aclk)
    begin
        if (!aresetn)
            clock_valid_q <= 1'b0;
        else if (pwr_lost)
            clock_valid_q <= 1'b0;
        else if (ld_cal && wb[`RTCA_MONITOR_BIT])
            clock_valid_q <= 1'b1;
    end

    // ========================================
    // Alarm settings and comparator commit
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            alm_sec_q <= `RTCA_RST_SEC;
            alm_min_q <= `RTCA_RST_SEC;
            alm_hour_q <= `RTCA_RST_HOUR;
            alm_day_q <= `RTCA_RST_DAY;
            alm_mon_q <= `RTCA_RST_MON;
            alm_year_q <= `RTCA_RST_YEAR;
            tick_wake_q <= 1'b0;
            tick_type_q <= 1'b0;
            tick_on_q <= 1'b0;
            alarm_on_q <= 1'b0;
            cmp_min_q <= `RTCA_RST_SEC;
            cmp_hour_q <= `RTCA_RST_HOUR;
            cmp_day_q <= `RTCA_RST_DAY;
            cmp_mon_q <= `RTCA_RST_MON;
            cmp_year_q <= `RTCA_RST_YEAR;
        end
        else if (wr_en)
        begin
            case (wr_idx)
                `RTCA_IDX_ALM_SEC: alm_sec_q <= wb[5:0];
                `RTCA_IDX_ALM_MIN: alm_min_q <= wb[5:0];
                `RTCA_IDX_ALM_HOUR: alm_hour_q <= wb[4:0];
                `RTCA_IDX_ALM_DAY: alm_day_q <= wb[4:0];
                `RTCA_IDX_ALM_MON:
                begin
                    alm_mon_q <= wb[3:0];
                    tick_wake_q <= wb[`RTCA_TICK_WAKE_BIT];
                    tick_type_q <= wb[`RTCA_TICK_TYPE_BIT];
                end
                `RTCA_IDX_ALM_YEAR:
                begin
                    alm_year_q <= wb[5:0];
                    tick_on_q <= wb[`RTCA_TICK_ON_BIT];
                    alarm_on_q <= wb[`RTCA_ALARM_ON_BIT];
                    cmp_min_q <= alm_min_q;
                    cmp_hour_q <= alm_hour_q;
                    cmp_day_q <= alm_day_q;
                    cmp_mon_q <= alm_mon_q;
                    cmp_year_q <= wb[5:0];
                end
                default: alm_sec_q <= alm_sec_q;
            endcase
        end
    end

    // ========================================
    // Events and alarm cause
    always @*
    begin
        tick_hit = chk_q && tick_on_q && (!tick_type_q || cal_sec == 6'h00);
        alarm_hit = chk_q && alarm_on_q && cal_sec == alm_sec_q && cal_min == cmp_min_q
            && cal_hour == cmp_hour_q && cal_day == cmp_day_q && cal_mon == cmp_mon_q
            && cal_year == cmp_year_q;
        cause_d = cause_q;
        // Cleared by reading; a new event in the same cycle survives
        if (rd_now && rd_ok_q && rd_idx_q == `RTCA_IDX_ALM_SEC)
            cause_d = `RTCA_CAUSE_NONE;
        if (tick_hit)
            cause_d = cause_d | `RTCA_CAUSE_TICK;
        if (alarm_hit)
            cause_d = cause_d | `RTCA_CAUSE_ALARM;
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cause_q <= `RTCA_CAUSE_NONE;
            tick_event_q <= 1'b0;
            alarm_event_q <= 1'b0;
            wake_q <= 1'b0;
        end
        else
        begin
            cause_q <= cause_d;
            tick_event_q <= tick_hit;
            alarm_event_q <= alarm_hit;
            wake_q <= (tick_hit && tick_wake_q) || alarm_hit;
        end
    end

endmodule // rtca_regs

//--- verification/rtca_regs_checker.sv
`timescale 1ns/1ns
// ========================================
// Port checker for the register block
module rtca_regs_checker
(
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Bus handshakes
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire [31:0] s_axi_rdata,
    // Supervision and events
    input wire pwr_lost,
    input wire tick_event_q,
    input wire alarm_event_q,
    input wire wake_q,
    input wire clock_valid_q
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_wr_req;
        s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
    endsequence
    sequence s_wr_ans;
        s_axi_awready && s_axi_wready ##1 s_axi_bvalid;
    endsequence
    sequence s_rd_req;
        s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
    endsequence
    sequence s_rd_ans;
        s_axi_arready ##1 s_axi_rvalid;
    endsequence

    a_write_answer:
        assert property (s_wr_req |=> s_wr_ans) else $error("write answer out of time");
    a_read_answer:
        assert property (s_rd_req |=> s_rd_ans) else $error("read answer out of time");
    a_rdata_upper_zero:
        assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("rdata upper set");
    a_alarm_wakes:
        assert property (alarm_event_q |-> wake_q) else $error("alarm without wake");
    a_wake_cause:
        assert property (wake_q |-> tick_event_q || alarm_event_q) else $error("wake without cause");
    a_tick_spacing:
        assert property (tick_event_q |=> !tick_event_q [*8]) else $error("ticks too close");
    a_monitor_lost:
        assert property (pwr_lost [*2] |-> !clock_valid_q) else $error("monitor kept on power loss");
    a_monitor_keep:
        assert property (clock_valid_q && !pwr_lost |=> clock_valid_q) else $error("monitor cleared");
endmodule // rtca_regs_checker

bind rtca_regs rtca_regs_checker i_rtca_regs_checker
(
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rdata,
    .pwr_lost, .tick_event_q, .alarm_event_q, .wake_q, .clock_valid_q
);

//--- verification/rtca_regs_test.sv
`timescale 1ns/1ns
// ========================================
// Register map regression
module rtca_regs_test;
    reg aclk = 1'b0;
    reg aresetn = 1'b0;
    reg [11:0] s_axi_awaddr = 12'h000;
    reg [11:0] s_axi_araddr = 12'h000;
    reg [31:0] s_axi_wdata = 32'h0;
    reg s_axi_awvalid = 1'b0;
    reg s_axi_wvalid = 1'b0;
    reg s_axi_bready = 1'b0;
    reg s_axi_arvalid = 1'b0;
    reg s_axi_rready = 1'b0;
    reg pwr_lost = 1'b0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire tick_event_q, alarm_event_q, wake_q, clock_valid_q;
    integer n_errors = 0;
    integer total_checks = 0;
    integer i, n_tick, n_wake;
    reg [1:0] resp;
    reg [31:0] rv;

    always #25 aclk = ~aclk;

    // Short second so a full rollover fits in a few hundred cycles
    rtca_regs #(.SEC_CYCLES(20), .HOLD_CYCLES(10)) i_rtca_regs
    (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'b000), .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'b000),
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .pwr_lost, .tick_event_q, .alarm_event_q, .wake_q, .clock_valid_q
    );

    // ========================================
    // Bus tasks
    task chk(input [31:0] seen, input [31:0] exp);
    begin
        total_checks = total_checks + 1;
        if (seen !== exp)
        begin
            n_errors = n_errors + 1;
            $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
        end
    end
    endtask

    task wr(input [7:0] idx, input [7:0] d);
    begin
        @(posedge aclk);
        s_axi_awaddr <= {2'b00, idx, 2'b00};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        @(posedge aclk);
        while (s_axi_awready !== 1'b1)
            @(posedge aclk);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        while (s_axi_bvalid !== 1'b1)
            @(posedge aclk);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    end
    endtask

    task rd(input [7:0] idx);
    begin
        @(posedge aclk);
        s_axi_araddr <= {2'b00, idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        @(posedge aclk);
        while (s_axi_arready !== 1'b1)
            @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1)
            @(posedge aclk);
        rv = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    end
    endtask

    task rdc(input [7:0] idx, input [31:0] exp);
    begin
        rd(idx);
        chk({30'h0, resp}, 32'h0);
        chk(rv, exp);
    end
    endtask

    task wrrd(input [7:0] idx, input [7:0] d, input [31:0] exp);
    begin
        wr(idx, d);
        rdc(idx, exp);
    end
    endtask

    // Counts event pulses over exactly two seconds
    task count40;
    begin
        n_tick = 0;
        n_wake = 0;
        repeat (40)
        begin
            @(posedge aclk);
            n_tick = n_tick + tick_event_q;
            n_wake = n_wake + wake_q;
        end
    end
    endtask

    task print_verdict;
    begin
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    end
    endtask

    // ========================================
    // Tests
    initial
    begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk({31'h0, clock_valid_q}, 32'h0);
        wrrd(8'h42, 8'hff, 32'h1f);
        wrrd(8'h43, 8'hff, 32'h1f);
        wrrd(8'h44, 8'hff, 32'h0f);
        wrrd(8'h46, 8'hff, 32'h3f);
        wrrd(8'h47, 8'hff, 32'h3f);
        wrrd(8'h48, 8'hff, 32'h1f);
        wrrd(8'h4a, 8'hff, 32'h3f);
        wrrd(8'h4b, 8'h00, 32'h00);
        $display("test fields done");
        wr(8'h40, 8'h3b);
        wrrd(8'h41, 8'h3b, 32'h3b);
        wr(8'h42, 8'h17);
        wr(8'h43, 8'h1f);
        wr(8'h44, 8'h0c);
        wr(8'h45, 8'h7f);
        chk({31'h0, clock_valid_q}, 32'h1);
        // Between one and two seconds elapse, so only seconds may differ
        repeat (24) @(posedge aclk);
        rd(8'h40);
        chk(rv & 32'hfe, 32'h80);
        rdc(8'h41, 32'h00);
        rdc(8'h42, 32'h00);
        rdc(8'h43, 32'h01);
        rdc(8'h44, 32'h01);
        rdc(8'h45, 32'h40);
        $display("test rollover done");
        wr(8'h46, 8'h0a);
        wr(8'h47, 8'h00);
        wr(8'h48, 8'h00);
        wr(8'h49, 8'h01);
        wr(8'h4a, 8'h01);
        wr(8'h4b, 8'h40);
        i = 0;
        while (alarm_event_q !== 1'b1 && i < 400)
        begin
            @(posedge aclk);
            i = i + 1;
        end
        chk({31'h0, alarm_event_q}, 32'h1);
        rdc(8'h46, 32'h8a);
        rdc(8'h46, 32'h0a);
        $display("test alarm done");
        wr(8'h4a, 8'h21);
        wr(8'h4b, 8'h80);
        count40;
        chk(n_tick, 32'h2);
        chk(n_wake, 32'h2);
        rdc(8'h46, 32'h4a);
        wr(8'h4a, 8'h11);
        count40;
        chk(n_tick, 32'h0);
        chk(n_wake, 32'h0);
        $display("test tick done");
        rd(8'h4c);
        chk({31'h0, rv == 32'h0}, 32'h0);
        rdc(8'h4d, 32'h0);
        rdc(8'h4e, 32'h0);
        rdc(8'h4f, 32'h0);
        $display("test counter done");
        wr(8'h45, 8'h00);
        chk({31'h0, clock_valid_q}, 32'h1);
        pwr_lost <= 1'b1;
        repeat (3) @(posedge aclk);
        pwr_lost <= 1'b0;
        chk({31'h0, clock_valid_q}, 32'h0);
        rdc(8'h45, 32'h00);
        $display("test monitor done");
        wr(8'h50, 8'h12);
        chk({30'h0, resp}, 32'h3);
        rd(8'h3f);
        chk({30'h0, resp}, 32'h3);
        chk(rv, 32'h0);
        $display("test decode done");
        print_verdict;
    end

    // Whole run is under two thousand cycles
    initial
    begin
        repeat (20000) @(posedge aclk);
        n_errors = n_errors + 1;
        $display("unexpected at %0t: watchdog expired", $time);
        print_verdict;
    end
endmodule // rtca_regs_test
